//--- rtl/ext_pin_change_input_defines.vh
// Offsets, field positions, reset values and codes for the flag block
//
// ==========================================================================
// Contract
// - Line 2, 1 or 0 sets its flag when its selected trigger occurs.
// - Line vector requested only with flag, mask bit and global enable; low-level mode requests from the low pin with no flag.
// - Executing a line or group routine clears the matching flag.
// - Writing one clears a flag bit; writing zero leaves it unchanged.
// - A line flag stays zero while low-level sensing is selected.
// - Group enables 0..3 cover inputs 7:0, 15:8, 23:16, 31:24; own vectors.
// - Any change on an enabled input of a group sets the group flag.
// - Group vector requested only with flag, group enable, global enable.
// - One mask bit per input in four 8-bit masks; cleared bit blocks it.
// - Change detected only when mask bit and group enable are both set.
// - Flag registers decode at data offset and at I/O address minus 0x20.
// - Registers at or above 0x60 reachable only by data-space accesses.
// - Sense code: 00 low level, 01 any change, 10 falling, 11 rising.
// - Line triggers are detected even when the pin drives as output.
// - Pins are sampled before edge detection; longer pulses always count.
`ifndef EXT_PIN_CHANGE_INPUT_DEFINES_VH
`define EXT_PIN_CHANGE_INPUT_DEFINES_VH

// ==========================================================================
// Data-space offsets
`define OFS_PC_FLAG 8'h3B
`define OFS_EXT_FLAG 8'h3C
`define OFS_EXT_MASK 8'h3D
`define OFS_PC_ENABLE 8'h68
`define OFS_LINE_SENSE 8'h69
`define OFS_PC_MASK0 8'h6B
`define OFS_PC_MASK1 8'h6C
`define OFS_PC_MASK2 8'h6D
`define OFS_PC_MASK3 8'h73

// ==========================================================================
// Address spaces
`define IO_SPACE_BASE 8'h20
`define EXT_IO_START 8'h60

// ==========================================================================
// Reset values
`define RST_REG8 8'h00
`define RST_SENSE 6'h00

// ==========================================================================
// Sense codes, two bits per line
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

// ==========================================================================
// Field positions in the request and acknowledge vectors
`define VEC_EXT_LSB 0
`define VEC_PC_LSB 3

`endif

//--- rtl/pin_sample_sync.v
// Pin synchroniser with previous-sample stage for change detection
module pin_sample_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,               // System clock
    input wire rst_b_i,             // Synchronous reset, active low
    input wire [WIDTH-1:0] pin_i,   // Raw pin levels
    output reg [WIDTH-1:0] cur_o,   // Synchronised sample
    output reg [WIDTH-1:0] prev_o   // Sample one cycle older
);

    reg [WIDTH-1:0] meta_r;

    // ======================================================================
    // Two-stage synchroniser, then one more stage to compare against
    // Only cur_o reads meta_r, so no logic sees a metastable level.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_r <= {WIDTH{1'b0}};
            cur_o <= {WIDTH{1'b0}};
            prev_o <= {WIDTH{1'b0}};
        end else begin
            meta_r <= pin_i;
            cur_o <= meta_r;
            prev_o <= cur_o;
        end
    end

endmodule

//--- rtl/line_sense_decode.v
// Trigger decode for one external line from its two-bit sense code
`include "ext_pin_change_input_defines.vh"

module line_sense_decode (
    input wire cur_i,          // Synchronised level
    input wire prev_i,         // Previous level
    input wire [1:0] sense_i,  // Sense selection
    output reg trig_o,         // Edge or change trigger this cycle
    output wire level_mode_o,  // Low-level sensing selected
    output wire level_low_o    // Low-level request condition
);

    // ======================================================================
    // Pin direction is not an input here, so outputs trigger too
    always @* begin
        case (sense_i)
            `SENSE_ANY: trig_o = cur_i ^ prev_i;
            `SENSE_FALL: trig_o = prev_i & ~cur_i;
            `SENSE_RISE: trig_o = cur_i & ~prev_i;
            default: trig_o = 1'b0;
        endcase
    end

    // Level mode asks directly from the sampled pin, no flag involved
    assign level_mode_o = (sense_i == `SENSE_LOW);
    assign level_low_o = level_mode_o & ~cur_i;

endmodule

//--- rtl/ext_pin_change_input_flags.v
// External line and pin-change flag, mask and request logic
`include "ext_pin_change_input_defines.vh"

module ext_pin_change_input_flags #(
    parameter LINES = 3,
    parameter GROUPS = 4,
    parameter GROUP_W = 8
) (
    input wire SYS_CLK_I,                    // System clock, 25 MHz
    input wire RST_B_I,                      // Sync reset, active low
    input wire [LINES-1:0] EXT_LINE_I,       // External line pins
    input wire [GROUPS*GROUP_W-1:0] PIN_CHANGE_I, // Pin-change inputs
    input wire [7:0] ADDR_I,                 // Register address
    input wire IO_SPACE_I,                   // High: I/O-space address
    input wire WR_EN_I,                      // Write strobe, one cycle
    input wire RD_EN_I,                      // Read strobe, one cycle
    input wire [7:0] WDATA_I,                // Write data
    output reg [7:0] RDATA_O,                // Read data, next cycle
    input wire GLOBAL_EN_I,                  // Core global enable bit
    input wire [LINES+GROUPS-1:0] VEC_EXEC_I, // Routine executed, pulse
    output wire [LINES+GROUPS-1:0] VEC_REQ_O // Vector requests, level
);

    localparam PINS = GROUPS * GROUP_W;

    // ======================================================================
    // Register state
    reg [LINES-1:0] ext_flag_r;
    reg [LINES-1:0] ext_flag_nxt;
    reg [LINES-1:0] ext_mask_r;
    reg [2*LINES-1:0] line_sense_r;
    reg [GROUPS-1:0] pc_flag_r;
    reg [GROUPS-1:0] pc_flag_nxt;
    reg [GROUPS-1:0] pc_enable_r;
    reg [PINS-1:0] pc_mask_r;
    reg [7:0] rdata_nxt;

    wire [7:0] eff_addr;
    wire [LINES-1:0] ext_cur;
    wire [LINES-1:0] ext_prev;
    wire [LINES-1:0] ext_trig;
    wire [LINES-1:0] ext_level;
    wire [LINES-1:0] ext_low;
    wire [PINS-1:0] pc_cur;
    wire [PINS-1:0] pc_prev;
    wire [PINS-1:0] pc_change;
    wire [PINS-1:0] pc_armed;
    wire [GROUPS-1:0] pc_set;
    wire [LINES-1:0] ext_exec;
    wire [GROUPS-1:0] pc_exec;
    wire ext_extra;
    wire io_ok;
    wire wr_ext_flag;
    wire wr_ext_mask;
    wire wr_sense;
    wire wr_pc_flag;
    wire wr_pc_enable;

    // ======================================================================
    // Address decode
    // I/O-space numbers are 0x00..0x3F and map 0x20 higher, so they can
    // never reach the extended area; an I/O address above 0x3F is dropped.
    assign eff_addr = IO_SPACE_I ? ADDR_I + `IO_SPACE_BASE : ADDR_I;
    assign io_ok = ~IO_SPACE_I | (ADDR_I < 8'h40);
    assign ext_extra = ~IO_SPACE_I & (eff_addr >= `EXT_IO_START);

    assign wr_ext_flag = WR_EN_I & io_ok & (eff_addr == `OFS_EXT_FLAG);
    assign wr_ext_mask = WR_EN_I & io_ok & (eff_addr == `OFS_EXT_MASK);
    assign wr_pc_flag = WR_EN_I & io_ok & (eff_addr == `OFS_PC_FLAG);
    assign wr_sense = WR_EN_I & ext_extra & (eff_addr == `OFS_LINE_SENSE);
    assign wr_pc_enable = WR_EN_I & ext_extra &
        (eff_addr == `OFS_PC_ENABLE);

    // ======================================================================
    // Pin synchronisers, one for the lines and one for all pin-change inputs
    pin_sample_sync #(
        .WIDTH(LINES)
    ) u_ext_sync (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .pin_i(EXT_LINE_I),
        .cur_o(ext_cur),
        .prev_o(ext_prev)
    );

    pin_sample_sync #(
        .WIDTH(PINS)
    ) u_pc_sync (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .pin_i(PIN_CHANGE_I),
        .cur_o(pc_cur),
        .prev_o(pc_prev)
    );

    // ======================================================================
    // Sense decode per external line
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi = gi + 1) begin : g_line
            line_sense_decode u_dec (
                .cur_i(ext_cur[gi]),
                .prev_i(ext_prev[gi]),
                .sense_i(line_sense_r[2*gi+1:2*gi]),
                .trig_o(ext_trig[gi]),
                .level_mode_o(ext_level[gi]),
                .level_low_o(ext_low[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Pin-change detection gated by mask bit and group enable
    assign pc_change = pc_cur ^ pc_prev;
    generate
        for (gi = 0; gi < GROUPS; gi = gi + 1) begin : g_grp
            // Group gi owns inputs gi*8+7 down to gi*8
            assign pc_armed[gi*GROUP_W +: GROUP_W] =
                pc_mask_r[gi*GROUP_W +: GROUP_W] &
                {GROUP_W{pc_enable_r[gi]}};
            assign pc_set[gi] =
                |(pc_change[gi*GROUP_W +: GROUP_W] &
                pc_armed[gi*GROUP_W +: GROUP_W]);
        end
    endgenerate

    // ======================================================================
    // Routine-executed pulses split by source
    assign ext_exec = VEC_EXEC_I[`VEC_EXT_LSB +: LINES];
    assign pc_exec = VEC_EXEC_I[`VEC_PC_LSB +: GROUPS];

    // ======================================================================
    // Flag next values
    // Set follows the exec and write-one clears, so a same-cycle clear never loses an event.
    always @* begin
        ext_flag_nxt = ext_flag_r;
        ext_flag_nxt = ext_flag_nxt & ~ext_exec;
        if (wr_ext_flag) begin
            ext_flag_nxt = ext_flag_nxt & ~WDATA_I[LINES-1:0];
        end
        ext_flag_nxt = ext_flag_nxt | ext_trig;
        ext_flag_nxt = ext_flag_nxt & ~ext_level;
        pc_flag_nxt = pc_flag_r & ~pc_exec;
        if (wr_pc_flag) begin
            pc_flag_nxt = pc_flag_nxt & ~WDATA_I[GROUPS-1:0];
        end
        pc_flag_nxt = pc_flag_nxt | pc_set;
    end

    // ======================================================================
    // Flag registers
    always @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            ext_flag_r <= {LINES{1'b0}};
            pc_flag_r <= {GROUPS{1'b0}};
        end else begin
            ext_flag_r <= ext_flag_nxt;
            pc_flag_r <= pc_flag_nxt;
        end
    end

    // ======================================================================
    // Control registers written by software
    always @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            ext_mask_r <= {LINES{1'b0}};
            line_sense_r <= `RST_SENSE;
            pc_enable_r <= {GROUPS{1'b0}};
            pc_mask_r <= {PINS{1'b0}};
        end else begin
            if (wr_ext_mask) begin
                ext_mask_r <= WDATA_I[LINES-1:0];
            end
            if (wr_sense) begin
                line_sense_r <= WDATA_I[2*LINES-1:0];
            end
            if (wr_pc_enable) begin
                pc_enable_r <= WDATA_I[GROUPS-1:0];
            end
            // Masks live only in the extended area
            if (WR_EN_I & ext_extra) begin
                case (eff_addr)
                    `OFS_PC_MASK0: pc_mask_r[7:0] <= WDATA_I;
                    `OFS_PC_MASK1: pc_mask_r[15:8] <= WDATA_I;
                    `OFS_PC_MASK2: pc_mask_r[23:16] <= WDATA_I;
                    `OFS_PC_MASK3: pc_mask_r[31:24] <= WDATA_I;
                    default: pc_mask_r <= pc_mask_r;
                endcase
            end
        end
    end

    // ======================================================================
    // Read mux; unmapped and reserved bits read as zero
    always @* begin
        rdata_nxt = `RST_REG8;
        if (io_ok && !ext_extra) begin
            case (eff_addr)
                `OFS_EXT_FLAG: rdata_nxt[LINES-1:0] = ext_flag_r;
                `OFS_EXT_MASK: rdata_nxt[LINES-1:0] = ext_mask_r;
                `OFS_PC_FLAG: rdata_nxt[GROUPS-1:0] = pc_flag_r;
                default: rdata_nxt = `RST_REG8;
            endcase
        end else if (ext_extra) begin
            case (eff_addr)
                `OFS_LINE_SENSE: rdata_nxt[2*LINES-1:0] = line_sense_r;
                `OFS_PC_ENABLE: rdata_nxt[GROUPS-1:0] = pc_enable_r;
                `OFS_PC_MASK0: rdata_nxt = pc_mask_r[7:0];
                `OFS_PC_MASK1: rdata_nxt = pc_mask_r[15:8];
                `OFS_PC_MASK2: rdata_nxt = pc_mask_r[23:16];
                `OFS_PC_MASK3: rdata_nxt = pc_mask_r[31:24];
                default: rdata_nxt = `RST_REG8;
            endcase
        end
    end

    // Read data held until the next read strobe
    always @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            RDATA_O <= `RST_REG8;
        end else if (RD_EN_I) begin
            RDATA_O <= rdata_nxt;
        end
    end

    // ======================================================================
    // Vector requests to the core
    // Level mode requests straight from the pin, so it lasts only while
    // the pin stays low; the core must take it before the level goes.
    assign VEC_REQ_O[`VEC_EXT_LSB +: LINES] =
        (ext_flag_r | ext_low) & ext_mask_r &
        {LINES{GLOBAL_EN_I}};
    assign VEC_REQ_O[`VEC_PC_LSB +: GROUPS] =
        pc_flag_r & pc_enable_r & {GROUPS{GLOBAL_EN_I}};

endmodule

//--- dv/ext_pin_change_input_flags_chk.sv
// Port assertions for the flag, mask and request block
module ext_pin_change_input_flags_chk #(
    parameter LINES = 3,
    parameter GROUPS = 4,
    parameter GROUP_W = 8
) (
    input wire logic SYS_CLK_I, // Clock
    input wire logic RST_B_I, // Reset
    input wire logic [LINES-1:0] EXT_LINE_I, // Lines
    input wire logic [GROUPS*GROUP_W-1:0] PIN_CHANGE_I, // Pins
    input wire logic [7:0] ADDR_I, // Address
    input wire logic IO_SPACE_I, // I/O space
    input wire logic WR_EN_I, // Write
    input wire logic RD_EN_I, // Read
    input wire logic [7:0] WDATA_I, // Write data
    input wire logic [7:0] RDATA_O, // Read data
    input wire logic GLOBAL_EN_I, // Global enable
    input wire logic [LINES+GROUPS-1:0] VEC_EXEC_I, // Executed
    input wire logic [LINES+GROUPS-1:0] VEC_REQ_O // Requests
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [GROUPS*GROUP_W-1:0] pc_prev_r;
    logic [LINES-1:0] ln_prev_r;
    logic [3:0] pc_q_r;
    logic [3:0] ln_q_r;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    // ====================
    // Quiet time since last pin edge; covers the sync pipeline depth
    always @(posedge SYS_CLK_I) begin
        pc_prev_r <= PIN_CHANGE_I;
        ln_prev_r <= EXT_LINE_I;
        if (!RST_B_I || PIN_CHANGE_I != pc_prev_r)
            pc_q_r <= 4'h0;
        else if (pc_q_r != 4'hF)
            pc_q_r <= pc_q_r + 4'h1;
        if (!RST_B_I || EXT_LINE_I != ln_prev_r)
            ln_q_r <= 4'h0;
        else if (ln_q_r != 4'hF)
            ln_q_r <= ln_q_r + 4'h1;
    end
    // ====================
    // Requests, flags and register decode
    AST_REQ_GLOBAL: assert property (
        VEC_REQ_O != 7'h00 |-> GLOBAL_EN_I) else $error("request w/o global");
    AST_EXEC_CLR: assert property (
        pc_q_r >= 4'h8 |=> (VEC_REQ_O[6:3] & $past(VEC_EXEC_I[6:3])) == 4'h0)
        else $error("exec left group request");
    AST_W1C: assert property (
        WR_EN_I && pc_q_r >= 4'h8 && ((!IO_SPACE_I && ADDR_I == 8'h3B) ||
        (IO_SPACE_I && ADDR_I == 8'h1B)) |=>
        (VEC_REQ_O[6:3] & $past(WDATA_I[3:0])) == 4'h0)
        else $error("write one kept flag");
    AST_PC_NO_RISE: assert property (
        pc_q_r >= 4'h8 && !WR_EN_I ##1 $stable(GLOBAL_EN_I) |->
        (VEC_REQ_O[6:3] & ~$past(VEC_REQ_O[6:3])) == 4'h0)
        else $error("group request without change");
    AST_LN_NO_RISE: assert property (
        ln_q_r >= 4'h8 && !WR_EN_I ##1 $stable(GLOBAL_EN_I) |->
        (VEC_REQ_O[2:0] & ~$past(VEC_REQ_O[2:0])) == 3'h0)
        else $error("line request without trigger");
    AST_IO_HIGH: assert property (
        RD_EN_I && IO_SPACE_I && ADDR_I >= 8'h40 |=> RDATA_O == 8'h00)
        else $error("extended place seen in I/O space");
    AST_RSV_LINE: assert property (
        RD_EN_I && ((ADDR_I | 8'h20) == 8'h3C || (ADDR_I | 8'h20) == 8'h3D)
        |=> RDATA_O[7:3] == 5'h00) else $error("line register top bits");
    AST_RSV_GRP: assert property (
        RD_EN_I && ((ADDR_I | 8'h20) == 8'h3B || ADDR_I == 8'h68)
        |=> RDATA_O[7:4] == 4'h0) else $error("group register top bits");
endmodule

bind ext_pin_change_input_flags ext_pin_change_input_flags_chk #(.LINES(LINES), .GROUPS(GROUPS),
    .GROUP_W(GROUP_W)) chk_inst (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
    .EXT_LINE_I(EXT_LINE_I), .PIN_CHANGE_I(PIN_CHANGE_I), .ADDR_I(ADDR_I),
    .IO_SPACE_I(IO_SPACE_I), .WR_EN_I(WR_EN_I), .RD_EN_I(RD_EN_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .GLOBAL_EN_I(GLOBAL_EN_I),
    .VEC_EXEC_I(VEC_EXEC_I), .VEC_REQ_O(VEC_REQ_O));

//--- dv/core_accept_model.sv
// Behavioural model of the core taking vector requests
module core_accept_model (
    input wire logic clk_i, // System clock
    input wire logic rst_b_i, // Sync reset, active low
    input wire logic [6:0] req_i, // Vector requests
    input wire logic accept_i, // Core may take requests
    input wire logic [3:0] wait_i, // Cycles before taking one
    output logic [6:0] exec_o // Routine executed, pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // ====================
    // Lowest vector wins; after a pulse the wait count restarts from zero
    always @(posedge clk_i) begin
        exec_o <= 7'h00;
        if (!rst_b_i || !accept_i || req_i == 7'h00 || exec_o != 7'h00) begin
            cnt_r <= 4'h0;
        end else if (cnt_r == wait_i) begin
            exec_o <= req_i & (~req_i + 7'h01);
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

//--- dv/ext_pin_change_input_flags_tb.sv
// Self-checking bench for the line and pin-change flag block
module ext_pin_change_input_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, io = 1'b0, wr = 1'b0, rd = 1'b0;
    logic gen = 1'b0, acc = 1'b0;
    logic [2:0] ext = 3'h0;
    logic [31:0] pc = 32'h0;
    logic [7:0] addr = 8'h00, wdat = 8'h00, r;
    logic [3:0] wt = 4'h0;
    wire [7:0] rdat;
    wire [6:0] req, exec;
    int fails = 0, n_compared = 0, cyc = 0;
    ext_pin_change_input_flags ext_pin_change_input_flags_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b),
        .EXT_LINE_I(ext), .PIN_CHANGE_I(pc), .ADDR_I(addr), .IO_SPACE_I(io),
        .WR_EN_I(wr), .RD_EN_I(rd), .WDATA_I(wdat), .RDATA_O(rdat),
        .GLOBAL_EN_I(gen), .VEC_EXEC_I(exec), .VEC_REQ_O(req));
    core_accept_model core_accept_model_inst (.clk_i(clk), .rst_b_i(rst_b),
        .req_i(req), .accept_i(acc), .wait_i(wt), .exec_o(exec));
    // ====================
    // Clock; whole run needs under 2000 cycles, so 5000 means a hang
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    // ====================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc_reg(input logic [7:0] a, input logic i, w,
                           input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        io <= i;
        wr <= w;
        rd <= !w;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdat;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Edge lands three edges later; six leaves margin
    task automatic toggle(input logic [2:0] e, input logic [31:0] p);
        @(posedge clk);
        ext <= ext ^ e;
        pc <= pc ^ p;
        idle(6);
    endtask
    task automatic ctl(input logic g, a, input logic [3:0] w);
        @(posedge clk);
        gen <= g;
        acc <= a;
        wt <= w;
        #1;
    endtask
    // ====================
    // Scenarios
    task automatic reset_values;
        logic [7:0] m [10] = '{8'h3B, 8'h3C, 8'h3D, 8'h68, 8'h69, 8'h6B,
                               8'h6C, 8'h6D, 8'h73, 8'h70};
        foreach (m[k]) begin
            acc_reg(m[k], 1'b0, 1'b0, 8'h00);
            chk("reset reg", 8'h00, r);
        end
    endtask
    task automatic group_flow(input int g);
        logic [7:0] ma [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};
        logic [31:0] p = 32'h1 << (9 * g);
        ctl(1'b1, 1'b0, 4'h0);
        acc_reg(ma[g], 1'b0, 1'b1, 8'h01 << g);
        toggle(3'h0, p);
        chk("group off", 8'h00, {1'b0, req});
        acc_reg(8'h68, 1'b0, 1'b1, 8'h01 << g);
        toggle(3'h0, p << 1);
        chk("pin masked", 8'h00, {1'b0, req});
        toggle(3'h0, p);
        chk("group req", 8'h08 << g, {1'b0, req});
        ctl(1'b0, 1'b0, 4'h0);
        chk("global off", 8'h00, {1'b0, req});
        acc_reg(8'h1B, 1'b1, 1'b0, 8'h00);
        chk("flag alias", 8'h01 << g, r);
        ctl(1'b1, 1'b0, 4'h0);
        acc_reg(8'h1B, 1'b1, 1'b1, 8'h00);
        chk("zero write", 8'h08 << g, {1'b0, req});
        acc_reg(8'h1B, 1'b1, 1'b1, 8'h0F);
        chk("one write", 8'h00, {1'b0, req});
        toggle(3'h0, p);
        ctl(1'b1, 1'b1, 4'(g));
        idle(8);
        chk("exec clear", 8'h00, {1'b0, req});
        ctl(1'b1, 1'b0, 4'h0);
    endtask
    task automatic line_modes(input int n);
        logic [7:0] b = 8'h01 << n;
        acc_reg(8'h3D, 1'b0, 1'b1, b);
        for (int s = 1; s < 4; s++) begin
            acc_reg(8'h69, 1'b0, 1'b1, 8'(s << (2 * n)));
            toggle(b[2:0], 32'h0);
            acc_reg(8'h3C, 1'b0, 1'b0, 8'h00);
            chk("rise flag", (s == 2) ? 8'h00 : b, r);
            // Any-change mode: routine clears the line flag, then a
            // pin change landing on a write-one clear must survive it
            if (s == 1) begin
                ctl(1'b1, 1'b1, 4'h0);
                idle(4);
                acc_reg(8'h1C, 1'b1, 1'b0, 8'h00);
                chk("line exec", 8'h00, r);
                ctl(1'b1, 1'b0, 4'h0);
                @(posedge clk);
                ext <= ext ^ b[2:0];
                @(posedge clk);
                acc_reg(8'h3C, 1'b0, 1'b1, 8'h07);
                acc_reg(8'h3C, 1'b0, 1'b0, 8'h00);
                chk("set wins", b, r);
                toggle(b[2:0], 32'h0);
            end
            acc_reg(8'h3C, 1'b0, 1'b1, 8'h07);
            toggle(b[2:0], 32'h0);
            acc_reg(8'h3C, 1'b0, 1'b0, 8'h00);
            chk("fall flag", (s == 3) ? 8'h00 : b, r);
            acc_reg(8'h3C, 1'b0, 1'b1, 8'h07);
        end
        acc_reg(8'h69, 1'b0, 1'b1, 8'h00);
        chk("level req", b, {1'b0, req});
        toggle(b[2:0], 32'h0);
        acc_reg(8'h3C, 1'b0, 1'b0, 8'h00);
        chk("level flag", 8'h00, r);
        chk("level gone", 8'h00, {1'b0, req});
    endtask
    task automatic io_refusal;
        acc_reg(8'h4B, 1'b1, 1'b1, 8'hFF);
        acc_reg(8'h6B, 1'b0, 1'b0, 8'h00);
        chk("io ext write", 8'h01, r);
        acc_reg(8'h4B, 1'b1, 1'b0, 8'h00);
        chk("io ext read", 8'h00, r);
        acc_reg(8'h1D, 1'b1, 1'b0, 8'h00);
        chk("mask alias", 8'h04, r);
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ====================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        reset_values();
        for (int g = 0; g < 4; g++)
            group_flow(g);
        for (int n = 0; n < 3; n++)
            line_modes(n);
        io_refusal();
        finish_test();
    end
endmodule
